// file: hw/iprg_link.sv
`timescale 1ns/10ps
module iprg_link (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sclk_rise,
  input wire logic load_s,
  input wire logic sin_s,
  input wire logic in_reset,
  input wire logic [31:0] resp_word,
  iprg_mem_if.engine mem,
  output logic prog_mode,
  output logic sout,
  output logic wdone_set,
  output logic busy,
  output logic [31:0] last_cmd
);
  typedef enum {IPRG_SHIFT, IPRG_LAUNCH, IPRG_WAIT, IPRG_ACK} iprg_st_t;
  iprg_st_t st_reg;
  logic [9:0] entry_reg;
  logic prog_reg;
  logic [31:0] cmd_reg;
  logic [31:0] out_reg;
  logic [31:0] next_reg;
  logic [1:0] pulse_reg;
  logic sout_reg;
  logic req_reg;
  logic wdone_reg;
  logic loaded_reg;
  logic [9:0] entry_next;
  logic entry_hit;
  logic shifting;
  logic cmd_read;
  assign entry_next = {entry_reg[8:0], sin_s};
  assign entry_hit = (entry_next == iprg_pkg::ENTRY_CODE);
  assign shifting = prog_reg && load_s && sclk_rise && (st_reg == IPRG_SHIFT);
  assign cmd_read = cmd_reg[iprg_pkg::BIT_READ];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      entry_reg <= '0;
    else if (in_reset && sclk_rise)
      entry_reg <= entry_next;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prog_reg <= 1'b0;
    else if (in_reset && sclk_rise && entry_hit)
      prog_reg <= 1'b1;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg <= IPRG_SHIFT;
      cmd_reg <= iprg_pkg::RST_WORD;
      out_reg <= iprg_pkg::RST_WORD;
      next_reg <= iprg_pkg::RST_WORD;
      pulse_reg <= 2'h0;
      sout_reg <= 1'b1;
      req_reg <= 1'b0;
      wdone_reg <= 1'b0;
      loaded_reg <= 1'b0;
    end
    else
    begin
      wdone_reg <= 1'b0;
      case (st_reg)
        IPRG_SHIFT:
        begin
          if (shifting)
          begin
            cmd_reg <= {cmd_reg[30:0], sin_s};
            out_reg <= {out_reg[30:0], 1'b0};
            // Bit stands from this rise, read 500 ns later
            sout_reg <= out_reg[31];
            loaded_reg <= 1'b1;
          end
          // Idle low strobe is no launch without a frame
          else if (loaded_reg && !load_s)
          begin
            st_reg <= IPRG_LAUNCH;
            pulse_reg <= 2'h0;
            loaded_reg <= 1'b0;
          end
        end
        IPRG_LAUNCH:
        begin
          if (sclk_rise)
          begin
            sout_reg <= 1'b0;
            pulse_reg <= pulse_reg + 2'h1;
            if (pulse_reg == 2'h1)
            begin
              req_reg <= 1'b1;
              st_reg <= IPRG_WAIT;
            end
          end
        end
        IPRG_WAIT:
        begin
          if (mem.done)
          begin
            req_reg <= 1'b0;
            next_reg <= {cmd_reg[31:8],
              cmd_read ? mem.rdata : cmd_reg[7:0]};
            wdone_reg <= !cmd_read;
            st_reg <= IPRG_ACK;
          end
        end
        IPRG_ACK:
        begin
          sout_reg <= 1'b1;
          out_reg <= next_reg;
          if (load_s)
          begin
            sout_reg <= next_reg[31];
            st_reg <= IPRG_SHIFT;
          end
        end
        default:
          st_reg <= IPRG_SHIFT;
      endcase
    end
  end
  assign mem.req = req_reg;
  assign mem.wr = !cmd_read;
  assign mem.data_sel = cmd_reg[iprg_pkg::BIT_DATA_SEL];
  assign mem.code_sel = cmd_reg[iprg_pkg::BIT_CODE_SEL];
  assign mem.addr = cmd_reg[iprg_pkg::ADDR_HI:iprg_pkg::ADDR_LO];
  assign mem.wdata = cmd_reg[7:0];
  assign prog_mode = prog_reg;
  assign sout = sout_reg;
  assign wdone_set = wdone_reg;
  assign busy = (st_reg != IPRG_SHIFT);
  assign last_cmd = cmd_reg;
endmodule

// file: hw/iprg_mem_if.sv
`timescale 1ns/10ps
interface iprg_mem_if;
  logic req;
  logic wr;
  logic data_sel;
  logic code_sel;
  logic [10:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport engine (output req, output wr, output data_sel, output code_sel,
    output addr, output wdata, input done, input rdata);
  modport port (input req, input wr, input data_sel, input code_sel,
    input addr, input wdata, output done, output rdata);
endinterface

// file: hw/iprg_pkg.sv
package iprg_pkg;
  localparam int CMD_W = 32;
  localparam int ENTRY_W = 10;
  localparam logic [9:0] ENTRY_CODE = 10'h34b;
  // Command word fields
  localparam int BIT_DATA_SEL = 29;
  localparam int BIT_CODE_SEL = 28;
  localparam int BIT_READ = 24;
  localparam int ADDR_HI = 18;
  localparam int ADDR_LO = 8;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_RDATA = 8'h0c;
  localparam logic [7:0] OFS_RESP = 8'h10;
  // Status bit positions
  localparam int ST_PROG = 0;
  localparam int ST_WDONE = 1;
  localparam int ST_REQ = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_INRST = 4;
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  // Sampling figure for the programmer; kept for reference
  localparam int T_ACCESS_NS = 500;
  localparam int CLK_NS = 50;
  localparam int T_ACCESS_CYC = T_ACCESS_NS / CLK_NS;
  typedef enum logic [1:0] {
    IPRG_OP_NONE,
    IPRG_OP_READ,
    IPRG_OP_WRITE
  } iprg_op_t;
endpackage

// file: hw/iprg_sync.sv
`timescale 1ns/10ps
module iprg_sync #(
  parameter int W = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;
  // First stage feeds only the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_reg <= '0;
      q_reg <= '0;
    end
    else
    begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end
  assign q = q_reg;
endmodule

// file: hw/iprg_top.sv
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
// Notes on behaviour
// - Entry opcode MSB first, clock rising
// - Match sets program-mode flag
// - No match at reset end: normal run
// - Four lines: strobe, in, out, clock
// - 32-bit command and response per transaction
// - Previous response shifts out simultaneously
// - First response word is undefined
// - Output low by second strobe-low edge
// - Write done sets complete status bit
// - Read byte loaded into low bits
// - Programming addresses equal normal addresses
// - Mode held until power off; zero bits (code clears the mode flag whenever aresetn is low)
// - Bit 29 data, bit 28 code
// - Bit 24: one read, zero write
// - Bits 18-8 address echoed; 7-0 data
module iprg_top #(
  parameter int MEM_WAIT = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_reset,
  input wire logic link_load,
  input wire logic link_sin,
  input wire logic link_sclk,
  output logic link_sout,
  output logic prog_mode,
  output logic mem_req,
  output logic mem_wr,
  output logic mem_data_sel,
  output logic mem_code_sel,
  output logic [10:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic mem_done,
  input wire logic [7:0] mem_rdata,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  iprg_mem_if mem ();
  logic [2:0] pins_s;
  logic load_s, sin_s, sclk_s, sclk_d_reg, sclk_rise;
  iprg_sync #(.W(3)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({link_load, link_sin, link_sclk}),
    .q(pins_s)
  );
  assign load_s = pins_s[2];
  assign sin_s = pins_s[1];
  assign sclk_s = pins_s[0];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sclk_d_reg <= 1'b0;
    else
      sclk_d_reg <= sclk_s;
  end
  assign sclk_rise = sclk_s && !sclk_d_reg;

  logic prog_w, sout_w, wdone_set, busy_w;
  logic [31:0] last_cmd;
  iprg_link u_link (
    .aclk(aclk),
    .aresetn(aresetn),
    .sclk_rise(sclk_rise),
    .load_s(load_s),
    .sin_s(sin_s),
    .in_reset(in_reset),
    .resp_word(32'h0000_0000),
    .mem(mem.engine),
    .prog_mode(prog_w),
    .sout(sout_w),
    .wdone_set(wdone_set),
    .busy(busy_w),
    .last_cmd(last_cmd)
  );

  // Memory side: external port, or local stand-in when software serves it
  logic ctrl_sw_reg, sw_done_reg, wdone_reg;
  logic [7:0] sw_rdata_reg;
  assign mem.done = ctrl_sw_reg ? sw_done_reg : mem_done;
  assign mem.rdata = ctrl_sw_reg ? sw_rdata_reg : mem_rdata;

  logic mem_req_reg, mem_wr_reg, mem_ds_reg, mem_cs_reg, sout_reg, prog_reg;
  logic [10:0] mem_addr_reg;
  logic [7:0] mem_wdata_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mem_req_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      mem_ds_reg <= 1'b0;
      mem_cs_reg <= 1'b0;
      mem_addr_reg <= '0;
      mem_wdata_reg <= '0;
      sout_reg <= 1'b1;
      prog_reg <= 1'b0;
    end
    else
    begin
      mem_req_reg <= mem.req && !ctrl_sw_reg && !mem_done;
      mem_wr_reg <= mem.wr;
      mem_ds_reg <= mem.data_sel;
      mem_cs_reg <= mem.code_sel;
      mem_addr_reg <= mem.addr;
      mem_wdata_reg <= mem.wdata;
      sout_reg <= sout_w;
      prog_reg <= prog_w;
    end
  end
  assign mem_req = mem_req_reg;
  assign mem_wr = mem_wr_reg;
  assign mem_data_sel = mem_ds_reg;
  assign mem_code_sel = mem_cs_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign link_sout = sout_reg;
  assign prog_mode = prog_reg;

  // AXI4-Lite slave
  logic awr_reg, wr_reg, bv_reg, arv_reg, rv_reg;
  logic [7:0] awa_reg;
  logic [31:0] wd_reg, rd_reg;
  logic [1:0] br_reg, rr_reg;
  logic do_wr, do_rd, wmap, rmap;
  logic [31:0] rsel;
  assign do_wr = awr_reg && wr_reg && !bv_reg;
  assign do_rd = s_axi_arvalid && !rv_reg;
  assign wmap = (awa_reg == iprg_pkg::OFS_CTRL) || (awa_reg == iprg_pkg::OFS_STATUS)
    || (awa_reg == iprg_pkg::OFS_RDATA);
  assign rmap = (s_axi_araddr[7:0] <= iprg_pkg::OFS_RESP) && (s_axi_araddr[1:0] == 2'h0)
    && (s_axi_araddr[31:8] == 24'h000000);
  assign rsel = (s_axi_araddr[7:0] == iprg_pkg::OFS_CTRL) ? {31'h0, ctrl_sw_reg} :
    (s_axi_araddr[7:0] == iprg_pkg::OFS_STATUS) ?
      {27'h0, in_reset, busy_w, mem.req, wdone_reg, prog_w} :
    (s_axi_araddr[7:0] == iprg_pkg::OFS_CMD) ? last_cmd :
    (s_axi_araddr[7:0] == iprg_pkg::OFS_RDATA) ? {24'h0, sw_rdata_reg} :
    {21'h0, mem.addr};
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awr_reg <= 1'b0;
      wr_reg <= 1'b0;
      awa_reg <= '0;
      wd_reg <= '0;
      bv_reg <= 1'b0;
      br_reg <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && !awr_reg)
      begin
        awr_reg <= 1'b1;
        awa_reg <= (s_axi_awaddr[31:8] == 24'h0) ? s_axi_awaddr[7:0] : 8'hff;
      end
      if (s_axi_wvalid && !wr_reg)
      begin
        wr_reg <= 1'b1;
        wd_reg <= s_axi_wdata;
      end
      if (do_wr)
      begin
        awr_reg <= 1'b0;
        wr_reg <= 1'b0;
        bv_reg <= 1'b1;
        br_reg <= wmap ? 2'h0 : 2'h2;
      end
      else if (bv_reg && s_axi_bready)
        bv_reg <= 1'b0;
    end
  end
  assign s_axi_awready = !awr_reg;
  assign s_axi_wready = !wr_reg;
  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp = br_reg;

  // Software registers; hardware set beats software clear
  logic clr_wdone, sw_ack;
  assign clr_wdone = do_wr && (awa_reg == iprg_pkg::OFS_STATUS) && wd_reg[iprg_pkg::ST_WDONE];
  assign sw_ack = do_wr && (awa_reg == iprg_pkg::OFS_RDATA);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_sw_reg <= 1'b0;
      wdone_reg <= 1'b0;
      sw_rdata_reg <= '0;
      sw_done_reg <= 1'b0;
    end
    else
    begin
      if (do_wr && (awa_reg == iprg_pkg::OFS_CTRL) && s_axi_wstrb[0])
        ctrl_sw_reg <= wd_reg[0];
      if (wdone_set)
        wdone_reg <= 1'b1;
      else if (clr_wdone)
        wdone_reg <= 1'b0;
      if (sw_ack && s_axi_wstrb[0])
        sw_rdata_reg <= wd_reg[7:0];
      sw_done_reg <= sw_ack && mem.req;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rv_reg <= 1'b0;
      rd_reg <= '0;
      rr_reg <= 2'h0;
      arv_reg <= 1'b0;
    end
    else
    begin
      arv_reg <= do_rd;
      if (do_rd)
      begin
        rv_reg <= 1'b1;
        rd_reg <= rmap ? rsel : 32'h0000_0000;
        rr_reg <= rmap ? 2'h0 : 2'h2;
      end
      else if (rv_reg && s_axi_rready)
        rv_reg <= 1'b0;
    end
  end
  assign s_axi_arready = !rv_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rdata = rd_reg;
  assign s_axi_rresp = rr_reg;
endmodule

// file: sim/iprg_assertions.sv
`timescale 1ns/10ps
module iprg_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_reset,
  input wire logic link_load,
  input wire logic link_sclk,
  input wire logic link_sout,
  input wire logic prog_mode,
  input wire logic mem_req,
  input wire logic mem_wr,
  input wire logic [10:0] mem_addr,
  input wire logic mem_done
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_idle_high;
    !prog_mode |-> link_sout;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("serial out low outside program mode");

  property p_mode_hold;
    prog_mode |=> prog_mode;
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("program mode dropped");

  property p_late_entry;
    !in_reset && !prog_mode |=> !prog_mode;
  endproperty
  a_late_entry: assert property (p_late_entry)
    else $error("program mode entered after reset interval");

  property p_req_mode;
    mem_req |-> prog_mode;
  endproperty
  a_req_mode: assert property (p_req_mode)
    else $error("memory request outside program mode");

  property p_req_busy;
    $rose(mem_req) |-> !link_sout && !link_load;
  endproperty
  a_req_busy: assert property (p_req_busy)
    else $error("memory request without busy or with strobe high");

  property p_busy_low;
    prog_mode && !link_load && $rose(link_sclk) |-> ##[1:8] !link_sout;
  endproperty
  a_busy_low: assert property (p_busy_low)
    else $error("busy not shown after strobe-low clock");

  property p_req_steady;
    mem_req && !mem_done |=> mem_req && $stable(mem_addr) && $stable(mem_wr);
  endproperty
  a_req_steady: assert property (p_req_steady)
    else $error("memory request changed before done");

  property p_busy_release;
    mem_req && mem_done |-> ##[1:6] link_sout;
  endproperty
  a_busy_release: assert property (p_busy_release)
    else $error("serial out not high after access done");
endmodule

bind iprg_top iprg_assertions chk_u (.aclk, .aresetn, .in_reset, .link_load, .link_sclk,
  .link_sout, .prog_mode, .mem_req, .mem_wr, .mem_addr, .mem_done);

// file: sim/iprg_prog_model.sv
`timescale 1ns/10ps
module iprg_prog_model (
  input wire logic aclk,
  input wire logic sout,
  output logic load,
  output logic sin,
  output logic sclk
);
  // Link clock stands still between frames
  initial
  begin
    load = 1'b0;
    sin = 1'b1;
    sclk = 1'b0;
  end

  // MSB first, sample 500 ns after rise
  task automatic shift(input logic [31:0] w, input int nb, output logic [31:0] r);
    r = 32'h0;
    sin = w[nb-1];
    #200;
    for (int i = nb - 1; i >= 0; i--)
    begin
      sclk = 1'b1;
      #100;
      if (i < nb - 1)
        r = {r[30:0], sout};
      #100 sclk = 1'b0;
      // Released line shows the inverse, not a held value
      sin = (i > 0) ? w[i-1] : ~w[0];
      #200;
    end
    #100 r = {r[30:0], sout};
  endtask

  task automatic enter(input logic [9:0] code);
    logic [31:0] d;
    // Pins move off the sampling edge
    #10;
    shift({22'h0, code}, 10, d);
  endtask

  task automatic xfer(input logic [31:0] cmd, output logic [31:0] resp, output logic ok);
    logic [31:0] d;
    int n;
    #10 load = 1'b1;
    #300 shift(cmd, 32, resp);
    load = 1'b0;
    #300 shift(32'h0, 2, d);
    // next strobe only once sout is high
    n = 0;
    while (!sout && n < 400)
    begin
      @(posedge aclk);
      n++;
    end
    ok = sout;
  endtask
endmodule

// file: sim/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic aclk, aresetn, in_reset, link_load, link_sin, link_sclk, link_sout, prog_mode;
  logic mem_req, mem_wr, mem_data_sel, mem_code_sel, mem_done, mem_seen;
  logic [10:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata;
  logic [21:0] cap;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int mismatches, n_checks;

  iprg_top dut_u (.aclk, .aresetn, .in_reset, .link_load, .link_sin, .link_sclk, .link_sout,
    .prog_mode, .mem_req, .mem_wr, .mem_data_sel, .mem_code_sel, .mem_addr, .mem_wdata,
    .mem_done, .mem_rdata, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  iprg_prog_model prog_u (.aclk, .sout(link_sout), .load(link_load), .sin(link_sin),
    .sclk(link_sclk));

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // One done pulse per request, byte derived from address
  always @(posedge aclk)
  begin
    mem_seen <= mem_req && (mem_seen || mem_done);
    mem_done <= mem_req && !mem_seen && !mem_done;
    mem_rdata <= mem_addr[7:0] ^ 8'h3c;
    if (mem_req && !mem_seen && !mem_done)
      cap <= {mem_wr, mem_data_sel, mem_code_sel, mem_addr, mem_wdata};
  end

  task automatic stop_test();
    $display("mismatches %0d checks %0d", mismatches, n_checks);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] r);
    int n;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      n++;
    end
    while (s_axi_bvalid !== 1'b1 && n < 100);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (s_axi_bvalid !== 1'b1)
    begin
      mismatches++;
      stop_test();
    end
  endtask

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      n++;
    end
    while (s_axi_rvalid !== 1'b1 && n < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (s_axi_rvalid !== 1'b1)
    begin
      mismatches++;
      stop_test();
    end
  endtask

  initial
  begin
    logic [31:0] cmd [5];
    logic [31:0] resp, d;
    logic [18:0] exp_resp;
    logic [1:0] r;
    logic ok;
    // Write data, read code, write code, two data reads
    cmd = '{32'h20003f5a, 32'h1103ff00, 32'h100400ff, 32'h21000100, 32'h21000000};
    {mismatches, n_checks, exp_resp} = '0;
    {aresetn, mem_done, mem_seen, mem_rdata, cap} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    in_reset = 1'b1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    prog_u.enter(10'h34a);
    @(posedge aclk);
    in_reset <= 1'b0;
    prog_u.enter(iprg_pkg::ENTRY_CODE);
    repeat (10) @(posedge aclk);
    chk({31'h0, prog_mode}, 32'h0);
    aresetn <= 1'b0;
    in_reset <= 1'b1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    prog_u.enter(iprg_pkg::ENTRY_CODE);
    @(posedge aclk);
    in_reset <= 1'b0;
    repeat (10) @(posedge aclk);
    chk({31'h0, prog_mode}, 32'h1);
    for (int i = 0; i < 5; i++)
    begin
      prog_u.xfer(cmd[i], resp, ok);
      chk({31'h0, ok}, 32'h1);
      if (!ok)
        stop_test();
      @(posedge aclk);
      chk({10'h0, cap}, {10'h0, ~cmd[i][24], cmd[i][29:28], cmd[i][18:0]});
      // First response is left unchecked, its content is undefined
      if (i > 0)
        chk({13'h0, resp[18:0]}, {13'h0, exp_resp});
      exp_resp = cmd[i][24] ? {cmd[i][18:8], cmd[i][15:8] ^ 8'h3c} : cmd[i][18:0];
      if (i == 0)
      begin
        axi_rd({24'h0, iprg_pkg::OFS_STATUS}, d, r);
        chk(d & 32'h3, 32'h3);
        axi_wr({24'h0, iprg_pkg::OFS_STATUS}, 32'h2, r);
        axi_rd({24'h0, iprg_pkg::OFS_STATUS}, d, r);
        chk(d & 32'h2, 32'h0);
        axi_rd({24'h0, iprg_pkg::OFS_CMD}, d, r);
        chk(d, cmd[0]);
        axi_rd(32'h40, d, r);
        chk({r, d[29:0]}, 32'h80000000);
        axi_wr(32'h40, 32'h1, r);
        chk({30'h0, r}, 32'h2);
      end
    end
    // Software serves one read; no external request may appear
    axi_wr({24'h0, iprg_pkg::OFS_CTRL}, 32'h1, r);
    fork
      prog_u.xfer(32'h21000200, resp, ok);
      begin
        repeat (300) @(posedge aclk);
        axi_rd({24'h0, iprg_pkg::OFS_RESP}, d, r);
        chk(d, 32'h0000_0002);
        axi_wr({24'h0, iprg_pkg::OFS_RDATA}, 32'h0000_00a5, r);
      end
    join
    chk({31'h0, ok}, 32'h1);
    chk({13'h0, resp[18:0]}, {13'h0, exp_resp});
    chk({10'h0, cap}, 32'h0010_0000);
    axi_wr({24'h0, iprg_pkg::OFS_CTRL}, 32'h0, r);
    prog_u.xfer(32'h21000000, resp, ok);
    chk({13'h0, resp[18:0]}, {13'h0, 11'h002, 8'ha5});
    stop_test();
  end
endmodule
